// file: tb.sv
// tb: self-checking bench for the crt controller front end
// assumes vct_host drives the port bus and the monitor is bound in
`timescale 1ns/10ps
module tb
   import vct_pkg::*;
   ;
   logic       clk = 1'b0, reset = 1'b1, io_sel = 1'b1, colour_emulation = 1'b1;
   logic       centered_mode = 1'b0, vertical_active = 1'b1, text_mode = 1'b1, ce = 1'b1;
   logic       bus_wr, bus_rd, bus_rvalid, display_enable, horizontal_blank;
   logic       horizontal_retrace, fetch_enable, image_size_mode, ok;
   logic [11:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata, d;
   logic [9:0] vertical_total, w, r, r0, len;
   logic [8:0] char_count;
   int         bad_count = 0, checks_done = 0;
   vct_crtc u_vct_crtc (.clk, .reset, .ce, .char_tick(1'b1), .colour_emulation,
      .centered_mode, .vertical_active, .text_mode, .io_sel, .bus_wr, .bus_rd, .bus_addr,
      .bus_wdata, .bus_rdata, .bus_rvalid, .display_enable, .horizontal_blank,
      .horizontal_retrace, .fetch_enable, .vertical_total, .image_size_mode, .char_count);
   vct_host u_vct_host (.clk, .io_sel, .colour_emulation, .bus_rvalid, .bus_rdata, .bus_wr,
      .bus_rd, .bus_addr, .bus_wdata);
   // 10 MHz clock
   initial
      forever #50 clk = ~clk;
   task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one settled line from a counter zero: width, rise offset and length
   task automatic meas(input int sel);
      logic s;
      int   n;
      {w, len, r} = {20'h00000, 10'h3ff};
      repeat (2)
      begin
         @(negedge clk);
         for (n = 0; n < 40 && char_count !== 9'h000; n++)
            @(negedge clk);
      end
      for (n = 0; n < 17; n++)
      begin
         s = sel == 0 ? display_enable : (sel == 1 ? horizontal_blank : horizontal_retrace);
         if (s === 1'b1 && r == 10'h3ff)
            r = 10'(n);
         w = w + 10'(s === 1'b1);
         if (n > 0 && char_count === 9'h000 && len == 10'h000)
            len = 10'(n);
         @(negedge clk);
      end
   endtask : meas
   task automatic t_reset;
      u_vct_host.rreg(VCT_IDX_HTOTAL, d, ok);
      chk("horizontal_total", 10'(d), 10'h000);
      u_vct_host.rreg(VCT_IDX_HSYNC_END, d, ok);
      chk("horizontal_sync_end_delay", 10'(d), 10'h000);
      u_vct_host.rreg(VCT_IDX_VTOTAL, d, ok);
      chk("vertical_total_low", 10'(d), 10'h000);
      u_vct_host.wreg(VCT_IDX_HBLANK_END, 8'h0c);
      u_vct_host.rreg(VCT_IDX_HBLANK_END, d, ok);
      chk("horizontal_blank_end_skew", 10'(d), 10'h08c);
   endtask : t_reset
   task automatic t_ports;
      for (int m = 0; m < 4; m++)
      begin
         {io_sel, colour_emulation} = 2'(m);
         u_vct_host.wreg(VCT_IDX_HSYNC_END, 8'(8'h10 + m));
         u_vct_host.rreg(VCT_IDX_HSYNC_END, d, ok);
         chk("data port", 10'(d), 10'(8'h10 + m));
         u_vct_host.cyc(1'b1, u_vct_host.port(1'b0), 8'h85);
         u_vct_host.rd(u_vct_host.port(1'b0), d, ok);
         chk("index port", 10'(d), 10'h005);
         u_vct_host.rd(colour_emulation ? VCT_IO_DATA_MONO : VCT_IO_DATA_COLOUR, d, ok);
         chk("foreign port answer", 10'(ok), 10'h000);
      end
   endtask : t_ports
   task automatic t_protect;
      u_vct_host.wreg(VCT_IDX_HTOTAL, 8'h0b);
      u_vct_host.wreg(VCT_IDX_PROTECT, 8'h80);
      u_vct_host.wreg(VCT_IDX_HTOTAL, 8'h22);
      u_vct_host.wreg(VCT_IDX_VOVERFLOW, 8'h21);
      u_vct_host.wreg(7'h08, 8'h5a);
      u_vct_host.rreg(VCT_IDX_HTOTAL, d, ok);
      chk("protected total", 10'(d), 10'h00b);
      u_vct_host.rreg(7'h08, d, ok);
      chk("unprotected index 8", 10'(d), 10'h05a);
      u_vct_host.wreg(VCT_IDX_PROTECT, 8'h00);
   endtask : t_protect
   task automatic t_line;
      u_vct_host.wreg(VCT_IDX_HTOTAL, 8'h0b);
      u_vct_host.wreg(VCT_IDX_HDISP_END, 8'h02);
      u_vct_host.wreg(VCT_IDX_HBLANK_ST, 8'h08);
      u_vct_host.wreg(VCT_IDX_HSYNC_ST, 8'h06);
      meas(0);
      r0 = r;
      chk("enable start", r, 10'h001);
      chk("line length", len, 10'h010);
      chk("fetch_enable", 10'(fetch_enable), 10'h001);
      for (int k = 0; k < 4; k++)
      begin
         u_vct_host.wreg(VCT_IDX_HBLANK_END, {1'b0, 2'(k), 5'h0c});
         meas(0);
         chk("enable width", w, 10'h003);
         chk("enable skew", r, 10'(r0 + 10'(k)));
      end
      u_vct_host.wreg(VCT_IDX_HBLANK_END, 8'h0c);
      u_vct_host.wreg(VCT_IDX_HDISP_END, 8'hff);
      meas(0);
      chk("oversized end width", w, 10'h00f);
      vertical_active = 1'b0;
      meas(0);
      chk("enable outside vertical active", w, 10'h000);
      vertical_active = 1'b1;
   endtask : t_line
   task automatic t_sync;
      meas(1);
      chk("blank width", w, 10'h004);
      u_vct_host.wreg(VCT_IDX_HSYNC_END, 8'h89);
      meas(1);
      chk("blank end high bit", w, 10'h011);
      for (int k = 0; k < 4; k++)
      begin
         u_vct_host.wreg(VCT_IDX_HSYNC_END, {1'b0, 2'(k), 5'h09});
         meas(2);
         chk("retrace width", w, 10'h003);
         chk("retrace delay", r, 10'(r0 + 10'h006 + 10'(k)));
      end
      u_vct_host.wreg(VCT_IDX_HSYNC_END, 8'h09);
      text_mode = 1'b0;
      meas(2);
      chk("graphics retrace delay", r, 10'(r0 + 10'h007));
      text_mode = 1'b1;
   endtask : t_sync
   task automatic t_misc;
      u_vct_host.wreg(VCT_IDX_VTOTAL, 8'h34);
      u_vct_host.wreg(VCT_IDX_VOVERFLOW, 8'h21);
      centered_mode = 1'b1;
      repeat (3) @(negedge clk);
      chk("vertical_total", vertical_total, 10'h334);
      chk("image_size_mode", 10'(image_size_mode), 10'h001);
      centered_mode = 1'b0;
      u_vct_host.wreg(VCT_IDX_HTOTAL, 8'h00);
      repeat (4) @(negedge clk);
      chk("fetch stopped", 10'({fetch_enable, display_enable, horizontal_retrace}), 10'h000);
      // clock enable low must hold the counter still
      ce = 1'b0;
      r  = 10'(char_count);
      repeat (3) @(negedge clk);
      chk("frozen char_count", 10'(char_count), r);
      ce = 1'b1;
   endtask : t_misc
   task automatic end_of_test;
      $display("checks_done %0d bad_count %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   // reset for 8 cycles, then the scenarios
   initial
   begin
      repeat (8) @(negedge clk);
      reset = 1'b0;
      t_reset();
      t_ports();
      t_protect();
      t_line();
      t_sync();
      t_misc();
      end_of_test();
   end
   // watchdog well beyond the expected run length
   initial
   begin
      #2000000;
      bad_count++;
      end_of_test();
   end
endmodule : tb

// file: vct_crtc.sv
// vct_crtc: crt controller index/data ports and horizontal timing generator
// assumes host bus strobes synchronous to clk, char_tick marks each character clock
//
// Contract
// R1: timing registers set display timing, or image size when centered mode is used
// R2: io index at 3b4h/3d4h, data at 3b5h/3d5h by miscellaneous_output bit 0
// R3: memory index at 3b4h/3d3h, data at 3b5h/3d5h by emulation mode
// R4: index bits 6:0 select register; index bit 7 reads zero
// R5: protection_control bit 7 blocks writes to registers 0 to 7
// R6: horizontal total is line length minus 5; zero stops display fetch
// R7: display enable rises at line start, falls at display end or total
// R8: oversized display end keeps enable on for all but last character
// R9: software puts blank start no earlier than end of active
// R10: blank end register bit 7 ignores writes, reads one
// R11: skew field delays display enable start and end by 0 to 3 characters
// R12: six bit blank end from blank end bits 4:0 and sync end bit 7
// R13: software sets blank end as low six bits of start plus length
// R14: sync start from active start, shifted further by sync delay field
// R15: sync delay field delays sync start and end by 0 to 3 characters
// R16: retrace drops when counter low five bits equal sync end field
// R17: ten bit vertical total from total register and overflow bits 0 and 5
// R18: software programs vertical total as scan lines minus 2
// R19: character counter starts at zero, wraps after total plus 5 counts
`timescale 1ns/10ps
module vct_crtc
   import vct_pkg::*;
   (input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        char_tick,
    input  wire logic        colour_emulation,
    input  wire logic        centered_mode,
    input  wire logic        vertical_active,
    input  wire logic        text_mode,
    input  wire logic        io_sel,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    input  wire logic [11:0] bus_addr,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata,
    output logic             bus_rvalid,
    output logic             display_enable,
    output logic             horizontal_blank,
    output logic             horizontal_retrace,
    output logic             fetch_enable,
    output logic      [9:0]  vertical_total,
    output logic             image_size_mode,
    output logic      [8:0]  char_count);

   logic [6:0] timing_index_select;
   logic       hit_index;
   logic       hit_data;
   logic       protected_now;
   logic       data_write;
   logic       data_write_ok;
   logic [7:0] store_data;
   logic [7:0] reg_rdata;
   logic       rd_index_d;
   logic       rd_data_d;
   logic [6:0] rd_index_q;
   logic [7:0] horizontal_total;
   logic [7:0] horizontal_display_end;
   logic [7:0] horizontal_blank_start;
   logic [7:0] horizontal_blank_end_skew;
   logic [7:0] horizontal_sync_start;
   logic [7:0] horizontal_sync_end_delay;
   logic [7:0] vertical_total_low;
   logic [7:0] vertical_overflow;
   logic [7:0] protection_control;
   logic [8:0] line_last;
   logic [5:0] blank_end_value;
   logic [1:0] skew;
   logic [1:0] sync_delay;
   logic [1:0] sync_shift;
   logic [3:0] de_pipe;
   logic [3:0] hs_pipe;
   logic       de_raw;
   logic       hb_raw;
   logic       hs_raw;
   logic       next_de_raw;
   logic       next_hb_raw;
   logic       next_hs_raw;
   logic [8:0] next_count;
   vct_state_t state;

   // port decode: io and memory windows per emulation mode
   always_comb
   begin
      hit_index = 1'b0;
      hit_data  = 1'b0;
      if (io_sel)
      begin
         hit_index = bus_addr == (colour_emulation ? VCT_IO_INDEX_COLOUR
                                                   : VCT_IO_INDEX_MONO); // R2
         hit_data  = bus_addr == (colour_emulation ? VCT_IO_DATA_COLOUR
                                                   : VCT_IO_DATA_MONO); // R2
      end
      else
      begin
         hit_index = bus_addr == (colour_emulation ? VCT_MM_INDEX_COLOUR
                                                   : VCT_MM_INDEX_MONO); // R3
         hit_data  = bus_addr == (colour_emulation ? VCT_MM_DATA_COLOUR
                                                   : VCT_MM_DATA_MONO); // R3
      end
   end

   // group 0 write protection on indices 0 through 7
   assign protected_now = protection_control[VCT_PROTECT_BIT]
                          && (timing_index_select <= VCT_IDX_PROT_LAST); // R5
   assign data_write    = bus_wr && hit_data;
   assign data_write_ok = data_write && !protected_now; // R5

   // index register, seven bits kept
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         timing_index_select <= VCT_RST_INDEX;
      else if (ce && bus_wr && hit_index)
         timing_index_select <= bus_wdata[6:0]; // R4
   end

   // reserved bit of blank end register is never stored
   always_comb
   begin
      store_data = bus_wdata;
      if (timing_index_select == VCT_IDX_HBLANK_END)
         store_data[VCT_RESERVED_BIT] = 1'b0; // R10
   end

   // general store for readback of indices 0 to 31
   vct_regfile #(.DEPTH(VCT_NREGS), .AW(5)) u_store
      (.clk   (clk),
       .reset (reset),
       .ce    (ce),
       .we    (data_write_ok && (timing_index_select < 7'(VCT_NREGS))),
       .waddr (timing_index_select[4:0]),
       .wdata (store_data),
       .raddr (timing_index_select[4:0]),
       .rdata (reg_rdata));

   // timing register copies that steer the generator
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         horizontal_total          <= VCT_RST_HTOTAL;
         horizontal_display_end    <= VCT_RST_OTHER;
         horizontal_blank_start    <= VCT_RST_OTHER;
         horizontal_blank_end_skew <= VCT_RST_OTHER;
         horizontal_sync_start     <= VCT_RST_OTHER;
         horizontal_sync_end_delay <= VCT_RST_HSYNC_END;
         vertical_total_low        <= VCT_RST_VTOTAL;
         vertical_overflow         <= VCT_RST_OTHER;
         protection_control        <= VCT_RST_OTHER;
      end
      else if (ce && data_write_ok)
      begin
         case (timing_index_select)
            VCT_IDX_HTOTAL:     horizontal_total          <= bus_wdata;
            VCT_IDX_HDISP_END:  horizontal_display_end    <= bus_wdata;
            VCT_IDX_HBLANK_ST:  horizontal_blank_start    <= bus_wdata;
            VCT_IDX_HBLANK_END: horizontal_blank_end_skew <= store_data; // R10
            VCT_IDX_HSYNC_ST:   horizontal_sync_start     <= bus_wdata;
            VCT_IDX_HSYNC_END:  horizontal_sync_end_delay <= bus_wdata;
            VCT_IDX_VTOTAL:     vertical_total_low        <= bus_wdata;
            VCT_IDX_VOVERFLOW:  vertical_overflow         <= bus_wdata;
            VCT_IDX_PROTECT:    protection_control        <= bus_wdata;
            default:            protection_control        <= protection_control;
         endcase
      end
   end

   // read path: two cycles after the strobe the data appears with rvalid
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         rd_index_d <= 1'b0;
         rd_data_d  <= 1'b0;
         rd_index_q <= 7'h00;
      end
      else if (ce)
      begin
         rd_index_d <= bus_rd && hit_index;
         rd_data_d  <= bus_rd && hit_data;
         rd_index_q <= timing_index_select;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         bus_rdata  <= 8'h00;
         bus_rvalid <= 1'b0;
      end
      else if (ce)
      begin
         bus_rvalid <= rd_index_d || rd_data_d;
         if (rd_index_d)
            bus_rdata <= {1'b0, rd_index_q}; // R4
         else if (rd_data_d && rd_index_q == VCT_IDX_HBLANK_END)
            bus_rdata <= reg_rdata | 8'h80; // R10
         else if (rd_data_d && rd_index_q < 7'(VCT_NREGS))
            bus_rdata <= reg_rdata;
         else
            bus_rdata <= 8'h00;
      end
   end

   // derived timing values
   assign line_last       = {1'b0, horizontal_total} + VCT_HTOTAL_ADD - 9'h001; // R19
   assign blank_end_value = {horizontal_sync_end_delay[VCT_BLANK_END_MSB],
                             horizontal_blank_end_skew[4:0]}; // R12
   assign skew            = horizontal_blank_end_skew[VCT_SKEW_LSB +: 2]; // R11
   assign sync_delay      = horizontal_sync_end_delay[VCT_SKEW_LSB +: 2]; // R15
   // graphics modes take one extra character of sync delay, saturating
   assign sync_shift      = (!text_mode && sync_delay != 2'h3) ? sync_delay + 2'h1
                                                               : sync_delay; // R14

   // line state: stopped while horizontal total is zero
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         state <= VCT_IDLE;
      else if (ce)
      begin
         case (state)
            VCT_IDLE:    state <= (horizontal_total != 8'h00) ? VCT_ACTIVE : VCT_STOPPED;
            VCT_ACTIVE:  state <= (horizontal_total == 8'h00) ? VCT_STOPPED : VCT_ACTIVE;
            VCT_STOPPED: state <= (horizontal_total != 8'h00) ? VCT_ACTIVE : VCT_STOPPED;
            default:     state <= VCT_IDLE;
         endcase
      end
   end

   // character counter
   assign next_count = (char_count >= line_last) ? 9'h000 : char_count + 9'h001; // R19

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         char_count <= 9'h000;
      else if (ce && char_tick)
         char_count <= next_count; // R19
   end

   // raw enable, blank and sync decided from the next count
   always_comb
   begin
      next_de_raw = de_raw;
      next_hb_raw = hb_raw;
      next_hs_raw = hs_raw;
      if (next_count == 9'h000)
         next_de_raw = vertical_active; // R7
      // display end beyond the line leaves the last character dark
      if (next_count == {1'b0, horizontal_display_end} + 9'h001
          || next_count == line_last) // R8
         next_de_raw = 1'b0; // R7
      if (next_count[7:0] == horizontal_blank_start)
         next_hb_raw = 1'b1;
      else if (hb_raw && next_count[5:0] == blank_end_value) // R12
         next_hb_raw = 1'b0;
      if (next_count[7:0] == horizontal_sync_start)
         next_hs_raw = 1'b1; // R14
      else if (hs_raw && next_count[4:0] == horizontal_sync_end_delay[4:0])
         next_hs_raw = 1'b0; // R16
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         de_raw <= 1'b0;
         hb_raw <= 1'b0;
         hs_raw <= 1'b0;
      end
      else if (ce && char_tick)
      begin
         de_raw <= next_de_raw;
         hb_raw <= next_hb_raw;
         hs_raw <= next_hs_raw;
      end
   end

   // character delay lines for skew and sync delay
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         de_pipe <= 4'h0;
         hs_pipe <= 4'h0;
      end
      else if (ce && char_tick)
      begin
         de_pipe <= {de_pipe[2:0], next_de_raw}; // R11
         hs_pipe <= {hs_pipe[2:0], next_hs_raw}; // R15
      end
   end

   // registered outputs
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         display_enable     <= 1'b0;
         horizontal_blank   <= 1'b0;
         horizontal_retrace <= 1'b0;
         fetch_enable       <= 1'b0;
         vertical_total     <= 10'h000;
         image_size_mode    <= 1'b0;
      end
      else if (ce)
      begin
         display_enable     <= de_pipe[skew] && state == VCT_ACTIVE; // R11
         horizontal_blank   <= hb_raw && state == VCT_ACTIVE;
         horizontal_retrace <= hs_pipe[sync_shift] && state == VCT_ACTIVE; // R15
         fetch_enable       <= state == VCT_ACTIVE; // R6
         vertical_total     <= {vertical_overflow[VCT_VT_BIT9],
                                vertical_overflow[VCT_VT_BIT8],
                                vertical_total_low}; // R17
         image_size_mode    <= centered_mode; // R1
      end
   end
endmodule : vct_crtc

// file: vct_crtc_monitor.sv
// vct_crtc_monitor: port-level checks of the crt controller front end
// assumes the counter steps only with ce and char_tick; bound into every vct_crtc instance
`timescale 1ns/10ps
module vct_crtc_monitor
   import vct_pkg::*;
   (input wire logic        clk,
    input wire logic        reset,
    input wire logic        ce,
    input wire logic        char_tick,
    input wire logic        colour_emulation,
    input wire logic        centered_mode,
    input wire logic        io_sel,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [11:0] bus_addr,
    input wire logic [7:0]  bus_wdata,
    input wire logic [7:0]  bus_rdata,
    input wire logic        bus_rvalid,
    input wire logic        fetch_enable,
    input wire logic        image_size_mode,
    input wire logic [8:0]  char_count);
   logic [6:0] sidx;
   logic       prot;
   logic [7:0] ht;
   wire logic  ih;
   wire logic  dh;
   // index and data port decode for the current space and emulation
   assign ih = bus_addr == (io_sel ? (colour_emulation ? VCT_IO_INDEX_COLOUR : VCT_IO_INDEX_MONO)
                                   : (colour_emulation ? VCT_MM_INDEX_COLOUR : VCT_MM_INDEX_MONO));
   assign dh = bus_addr == (colour_emulation ? VCT_IO_DATA_COLOUR : VCT_IO_DATA_MONO);
   // shadow of index, protect bit and total, taken from host writes
   always_ff @(posedge clk or posedge reset)
      if (reset)
      begin
         sidx <= VCT_RST_INDEX;
         prot <= 1'b0;
         ht   <= VCT_RST_HTOTAL;
      end
      else if (bus_wr && ih)
         sidx <= bus_wdata[6:0];
      else if (bus_wr && dh && sidx == VCT_IDX_PROTECT)
         prot <= bus_wdata[VCT_PROTECT_BIT];
      else if (bus_wr && dh && sidx == VCT_IDX_HTOTAL && !prot)
         ht <= bus_wdata;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   property p_idx7; bus_rd && ih |-> ##2 bus_rvalid && bus_rdata == {1'b0, $past(sidx, 2)}; endproperty
   a_idx7: assert property (p_idx7) else $error("index readback wrong");
   property p_miss; bus_rd && !ih && !dh |-> ##2 !bus_rvalid; endproperty
   a_miss: assert property (p_miss) else $error("answer to a foreign port");
   property p_step; ce && char_tick && ht != 8'h00 && $past(ht) != 8'h00
      && char_count < ({1'b0, ht} + 9'h004) |=> char_count == $past(char_count) + 9'h001; endproperty
   a_step: assert property (p_step) else $error("counter did not advance");
   property p_wrap; ce && char_tick && ht != 8'h00 && char_count == {1'b0, ht} + 9'h004
      |=> char_count == 9'h000; endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap");
   property p_fetch; (ht == 8'h00) [*3] |-> !fetch_enable; endproperty
   a_fetch: assert property (p_fetch) else $error("fetch on with zero total");
   property p_image; !$past(reset) |-> image_size_mode == $past(centered_mode); endproperty
   a_image: assert property (p_image) else $error("image size mode wrong");
   property p_bend7; bus_rd && dh && sidx == VCT_IDX_HBLANK_END |-> ##2 bus_rdata[7]; endproperty
   a_bend7: assert property (p_bend7) else $error("blank end bit 7 not one");
   property p_prot; bus_rd && dh && sidx == VCT_IDX_HTOTAL |-> ##2 bus_rdata == $past(ht, 2); endproperty
   a_prot: assert property (p_prot) else $error("total readback wrong");
   // main scenarios
   c_wrap: cover property (char_count == 9'h000 && fetch_enable);
   c_blocked: cover property (prot && bus_wr && dh);
   c_miss: cover property (bus_rd && !ih && !dh);
endmodule : vct_crtc_monitor
bind vct_crtc vct_crtc_monitor u_vct_crtc_monitor (.clk, .reset, .char_tick, .colour_emulation,
   .centered_mode, .io_sel, .bus_wr, .bus_rd, .bus_addr, .bus_wdata, .bus_rdata, .bus_rvalid,
   .fetch_enable, .image_size_mode, .char_count, .ce);

// file: vct_host.sv
// vct_host: host model issuing port reads and writes
// assumes the testbench sets decode space and emulation selects
`timescale 1ns/10ps
module vct_host
   import vct_pkg::*;
   (input  wire logic        clk,
    input  wire logic        io_sel,
    input  wire logic        colour_emulation,
    input  wire logic        bus_rvalid,
    input  wire logic [7:0]  bus_rdata,
    output logic             bus_wr,
    output logic             bus_rd,
    output logic      [11:0] bus_addr,
    output logic      [7:0]  bus_wdata);
   // idle bus at time zero
   initial
   begin
      bus_wr    = 1'b0;
      bus_rd    = 1'b0;
      bus_addr  = 12'h000;
      bus_wdata = 8'h00;
   end
   // one strobe cycle; afterwards the bus shows inverted values, never stale ones
   task automatic cyc(input logic wr, input logic [11:0] a, input logic [7:0] d);
      @(negedge clk);
      bus_wr    = wr;
      bus_rd    = !wr;
      bus_addr  = a;
      bus_wdata = d;
      @(negedge clk);
      bus_wr    = 1'b0;
      bus_rd    = 1'b0;
      bus_addr  = ~a;
      bus_wdata = ~d;
   endtask : cyc
   // data port is shared, the index port moves in colour memory space
   function automatic logic [11:0] port(input logic data);
      if (data)
         return colour_emulation ? VCT_IO_DATA_COLOUR : VCT_IO_DATA_MONO;
      if (io_sel)
         return colour_emulation ? VCT_IO_INDEX_COLOUR : VCT_IO_INDEX_MONO;
      return colour_emulation ? VCT_MM_INDEX_COLOUR : VCT_MM_INDEX_MONO;
   endfunction : port
   // read strobe, then a bounded wait; no answer leaves the data unknown so compares trip
   task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic ok);
      cyc(1'b0, a, 8'h00);
      ok = 1'b0;
      d  = 'x;
      repeat (4)
      begin
         if (bus_rvalid === 1'b1 && !ok)
         begin
            ok = 1'b1;
            d  = bus_rdata;
         end
         @(negedge clk);
      end
   endtask : rd
   // index write followed by a data access
   task automatic wreg(input logic [6:0] i, input logic [7:0] d);
      cyc(1'b1, port(1'b0), {1'b0, i});
      cyc(1'b1, port(1'b1), d);
   endtask : wreg
   task automatic rreg(input logic [6:0] i, output logic [7:0] d, output logic ok);
      cyc(1'b1, port(1'b0), {1'b0, i});
      rd(port(1'b1), d, ok);
   endtask : rreg
endmodule : vct_host

// file: vct_pkg.sv
// vct_pkg: constants for the crt controller horizontal timing front end
// assumes a byte-wide legacy port bus and a character clock enable from the pixel path
package vct_pkg;
   // port addresses
   localparam logic [11:0] VCT_IO_INDEX_MONO   = 12'h3b4;
   localparam logic [11:0] VCT_IO_INDEX_COLOUR = 12'h3d4;
   localparam logic [11:0] VCT_IO_DATA_MONO    = 12'h3b5;
   localparam logic [11:0] VCT_IO_DATA_COLOUR  = 12'h3d5;
   localparam logic [11:0] VCT_MM_INDEX_MONO   = 12'h3b4;
   localparam logic [11:0] VCT_MM_INDEX_COLOUR = 12'h3d3;
   localparam logic [11:0] VCT_MM_DATA_MONO    = 12'h3b5;
   localparam logic [11:0] VCT_MM_DATA_COLOUR  = 12'h3d5;
   // register indices
   localparam logic [6:0] VCT_IDX_HTOTAL      = 7'h00;
   localparam logic [6:0] VCT_IDX_HDISP_END   = 7'h01;
   localparam logic [6:0] VCT_IDX_HBLANK_ST   = 7'h02;
   localparam logic [6:0] VCT_IDX_HBLANK_END  = 7'h03;
   localparam logic [6:0] VCT_IDX_HSYNC_ST    = 7'h04;
   localparam logic [6:0] VCT_IDX_HSYNC_END   = 7'h05;
   localparam logic [6:0] VCT_IDX_VTOTAL      = 7'h06;
   localparam logic [6:0] VCT_IDX_VOVERFLOW   = 7'h07;
   localparam logic [6:0] VCT_IDX_PROTECT     = 7'h11;
   localparam logic [6:0] VCT_IDX_PROT_LAST   = 7'h07;
   // field positions
   localparam int VCT_PROTECT_BIT   = 7;
   localparam int VCT_SKEW_LSB      = 5;
   localparam int VCT_BLANK_END_MSB = 7;
   localparam int VCT_VT_BIT8       = 0;
   localparam int VCT_VT_BIT9       = 5;
   localparam int VCT_RESERVED_BIT  = 7;
   // reset values
   localparam logic [7:0] VCT_RST_HTOTAL   = 8'h00;
   localparam logic [7:0] VCT_RST_HSYNC_END = 8'h00;
   localparam logic [7:0] VCT_RST_VTOTAL   = 8'h00;
   localparam logic [7:0] VCT_RST_OTHER    = 8'h00;
   localparam logic [6:0] VCT_RST_INDEX    = 7'h00;
   // timing offsets in character clocks
   localparam logic [8:0] VCT_HTOTAL_ADD   = 9'h005;
   // register file depth
   localparam int VCT_NREGS = 32;
   typedef enum logic [1:0] {VCT_IDLE, VCT_ACTIVE, VCT_STOPPED} vct_state_t;
endpackage : vct_pkg

// file: vct_regfile.sv
// vct_regfile: small register store for the timing registers
// assumes one write or read per cycle; read data is registered
`timescale 1ns/10ps
module vct_regfile
   #(parameter int DEPTH = 32,
     parameter int AW    = 5)
   (input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          ce,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata);

   logic [7:0] mem [DEPTH];

   // storage, cleared at reset
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem[i] <= 8'h00;
      end
      else if (ce && we)
         mem[waddr] <= wdata;
   end

   // registered read port
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         rdata <= 8'h00;
      else if (ce)
         rdata <= mem[raddr];
   end
endmodule : vct_regfile
